// ===== hw/gio_cell.sv
// gpio logic cell: receive, transmit, drive enable, pulls, apb config
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module gio_cell
  import gio_pkg::*;
(
  input  wire logic              clk,                  // 10 mhz system clock
  input  wire logic              rst_n,                // async reset, active low
  input  wire logic              ce,                   // clock enable, freezes state
  input  wire logic              psel,                 // apb select
  input  wire logic              penable,              // apb access phase
  input  wire logic              pwrite,               // apb write
  input  wire logic [31:0]       paddr,                // apb byte address
  input  wire logic [31:0]       pwdata,               // apb write data
  output      logic [31:0]       prdata,               // apb read data
  output      logic              pready,               // apb ready
  output      logic              pslverr,              // apb error
  input  wire logic              configuring,          // device in configuration
  input  wire logic              in_clk,               // core input clock
  input  wire logic              out_clk,              // core output clock
  input  wire logic              rise_word_from_core,  // normal or rising data
  input  wire logic              fall_word_from_core,  // falling data
  input  wire logic              oe_from_core,         // core drive enable
  output      logic              rise_sample_to_core,  // normal or rising sample
  output      logic              fall_sample_to_core,  // falling sample
  output      logic              alt_to_net,           // alternate route out
  output      logic              pll_ref_clk,          // pad as pll reference
  input  wire logic              pad_in,               // pad level in
  output      gio_pkg::gio_pad_type pad                // pad drive and pulls
);
  import gio_pkg::*;

  gio_cfg_type  cfg;            // control register
  gio_stat_type stat;           // status view
  logic [1:0]   pad_sync;       // pad synchroniser
  logic [1:0]   ic_sync;        // input clock synchroniser
  logic [1:0]   oc_sync;        // output clock synchroniser
  logic         ic_prev;        // last input clock level
  logic         oc_prev;        // last output clock level
  logic         ic_rise;        // input clock rising
  logic         ic_fall;        // input clock falling
  logic         oc_rise;        // output clock rising
  logic         oc_fall;        // output clock falling
  logic         rx_q;           // single capture register
  logic         rx_rise_q;      // double-edge rise capture
  logic         rx_fall_q;      // double-edge fall capture
  logic         rx_fall_hold;   // fall capture moved to rise
  logic         tx_q;           // single transmit register
  logic         tx_rise_q;      // double-edge rise word
  logic         tx_fall_q;      // double-edge fall word
  logic         oe_q;           // drive-enable register
  logic         rx_on;          // receive path active
  logic         tx_on;          // transmit path active
  logic         double_edge_io_in_ok;     // double-edge receive allowed
  logic         double_edge_io_out_ok;    // double-edge transmit allowed
  logic         next_rise_s;    // next rise sample
  logic         next_fall_s;    // next fall sample
  logic         next_out;       // next pad data
  logic         next_drive;     // next driver state
  logic         next_pu;        // next pull-up
  logic         next_pd;        // next pull-down
  logic         acc;            // apb access phase
  logic         hit_ctrl;       // control address
  logic         hit_stat;       // status address

  // decode of the active mode
  assign rx_on = (cfg.mode == GIO_MODE_INPUT) || (cfg.mode == GIO_MODE_BIDIR);
  assign tx_on = (cfg.mode == GIO_MODE_OUTPUT) || (cfg.mode == GIO_MODE_BIDIR);
  assign double_edge_io_in_ok  = cfg.double_edge_io_in & ~cfg.diff_pin;
  assign double_edge_io_out_ok = cfg.double_edge_io_out & ~cfg.diff_pin;

  // apb decode, zero wait states
  assign acc      = psel & penable;
  assign hit_ctrl = (paddr == GIO_CTRL_OFS);
  assign hit_stat = (paddr == GIO_STATUS_OFS);
  assign pready   = 1'b1;
  assign pslverr  = acc & ~hit_ctrl & ~hit_stat;

  // writes to status or unmapped offsets are dropped here
  // control register write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= gio_cfg_type'(GIO_CTRL_RST[GIO_CTRL_W-1:0]);
    end else if (ce && acc && pwrite && hit_ctrl) begin
      cfg <= gio_cfg_type'(pwdata[GIO_CTRL_W-1:0]);
    end
  end

  // pad bit is the synchronised level, not the raw pin
  // status view of the cell
  always_comb begin
    stat.pad         = pad_sync[1];
    stat.rise_s      = rise_sample_to_core;
    stat.fall_s      = fall_sample_to_core;
    stat.configuring = configuring;
    stat.driving     = ~pad.oe_n;
    stat.pull_up     = pad.pull_up;
    stat.pull_dn     = pad.pull_dn;
  end

  // loads in the setup cycle so it stands through the access phase
  // registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      if (paddr == GIO_CTRL_OFS) begin
        prdata <= {{(32-GIO_CTRL_W){1'b0}}, cfg};
      end else if (paddr == GIO_STATUS_OFS) begin
        prdata <= {{(32-GIO_STAT_W){1'b0}}, stat};
      end else begin
        prdata <= 32'h0000_0000;  // unmapped reads zero
      end
    end
  end

  // only the second flop of each pair feeds any logic
  // two-flop synchronisers for pad and clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_sync <= 2'h0;
      ic_sync  <= 2'h0;
      oc_sync  <= 2'h0;
    end else if (ce) begin
      pad_sync <= {pad_sync[0], pad_in};
      ic_sync  <= {ic_sync[0], in_clk};
      oc_sync  <= {oc_sync[0], out_clk};
    end
  end

  // edges show two clk late; core clocks must run far below clk
  // clock edge detection after the synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ic_prev <= 1'b0;
      oc_prev <= 1'b0;
    end else if (ce) begin
      ic_prev <= ic_sync[1];
      oc_prev <= oc_sync[1];
    end
  end
  assign ic_rise = ic_sync[1] & ~ic_prev;
  assign ic_fall = ~ic_sync[1] & ic_prev;
  assign oc_rise = oc_sync[1] & ~oc_prev;
  assign oc_fall = ~oc_sync[1] & oc_prev;

  // single capture register on chosen input edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 1'b0;
    end else if (ce && (cfg.in_fall ? ic_fall : ic_rise)) begin
      rx_q <= pad_sync[1];
    end
  end

  // double-edge capture pair and resync hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_rise_q    <= 1'b0;
      rx_fall_q    <= 1'b0;
      rx_fall_hold <= 1'b0;
    end else if (ce) begin
      if (ic_rise) begin
        rx_rise_q    <= pad_sync[1];
        rx_fall_hold <= rx_fall_q;
      end
      if (ic_fall) begin
        rx_fall_q <= pad_sync[1];
      end
    end
  end

  // sample selection toward the core
  always_comb begin
    next_rise_s = 1'b0;
    next_fall_s = 1'b0;
    if (rx_on) begin
      if (double_edge_io_in_ok) begin
        next_rise_s = rx_rise_q;
        next_fall_s = cfg.resync ? rx_fall_hold : rx_fall_q;
      end else if (cfg.in_reg) begin
        next_rise_s = rx_q;
      end else begin
        next_rise_s = pad_sync[1];
      end
    end
  end

  // samples to core from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sample_to_core <= 1'b0;
      fall_sample_to_core <= 1'b0;
    end else if (ce) begin
      rise_sample_to_core <= next_rise_s;
      fall_sample_to_core <= next_fall_s;
    end
  end

  // no register here, so it tracks the pin two clk late
  // alternate route, combinational beyond the synchroniser
  assign alt_to_net  = pad_sync[1];
  assign pll_ref_clk = pad_sync[1];

  // single transmit register on chosen output edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 1'b0;
    end else if (ce && (cfg.out_fall ? oc_fall : oc_rise)) begin
      tx_q <= rise_word_from_core;
    end
  end

  // double-edge transmit words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_rise_q <= 1'b0;
      tx_fall_q <= 1'b0;
    end else if (ce) begin
      if (oc_rise) begin
        tx_rise_q <= rise_word_from_core;
      end
      if (cfg.resync ? oc_rise : oc_fall) begin
        tx_fall_q <= fall_word_from_core;
      end
    end
  end

  // shares the output clock with the transmit register
  // drive-enable register on chosen output edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (ce && (cfg.oe_fall ? oc_fall : oc_rise)) begin
      oe_q <= oe_from_core;
    end
  end

  // double_edge_io mux follows the synchronised out_clk level
  // pad data, driver and pull selection
  always_comb begin
    next_out   = 1'b0;
    next_drive = 1'b0;
    next_pu    = 1'b0;
    next_pd    = 1'b0;
    if (tx_on) begin
      if (double_edge_io_out_ok) begin
        next_out = oc_sync[1] ? tx_rise_q : tx_fall_q;
      end else if (cfg.out_reg) begin
        next_out = tx_q ^ cfg.invert;
      end else begin
        next_out = rise_word_from_core;
      end
    end
    if (cfg.mode == GIO_MODE_OUTPUT) begin
      next_drive = 1'b1;
    end else if (cfg.mode == GIO_MODE_BIDIR) begin
      next_drive = cfg.oe_reg ? oe_q : oe_from_core;
    end else if (cfg.mode == GIO_MODE_CLKOUT) begin
      next_out   = oc_sync[1];
      next_drive = 1'b1;
    end
    if (configuring) begin
      next_drive = 1'b0;
      next_pu    = ~cfg.diff_pin;
    end else if (!next_drive) begin
      next_pu = ~cfg.pull_down | cfg.diff_pin;
      next_pd = cfg.pull_down & ~cfg.diff_pin;
    end
  end

  // pad outputs from flops, glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad.out     <= 1'b0;
      pad.oe_n    <= 1'b1;
      pad.pull_up <= 1'b1;
      pad.pull_dn <= 1'b0;
    end else if (ce) begin
      pad.out     <= next_out;
      pad.oe_n    <= ~next_drive;
      pad.pull_up <= next_pu;
      pad.pull_dn <= next_pd;
    end
  end

  // checks on the cell
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_cfg_pullup: assert property (ce && configuring && !cfg.diff_pin |=>
    pad.pull_up && pad.oe_n) else $error("no pull-up in configuration");
  chk_cfg_float: assert property (ce && configuring && cfg.diff_pin |=>
    !pad.pull_up && !pad.pull_dn && pad.oe_n) else $error("diff pin not floating");
  chk_unused_pull: assert property (ce && !configuring &&
    cfg.mode == GIO_MODE_UNUSED && !cfg.pull_down |=> pad.oe_n && pad.pull_up)
    else $error("unused pin not pulled up");
  chk_pull_down: assert property (ce && !configuring && cfg.pull_down &&
    !cfg.diff_pin && cfg.mode == GIO_MODE_UNUSED |=> pad.pull_dn && !pad.pull_up)
    else $error("pull-down not applied");
  chk_in_direct: assert property (ce && rx_on && !double_edge_io_in_ok && !cfg.in_reg
    |=> rise_sample_to_core == $past(pad_sync[1])) else $error("direct receive wrong");
  chk_rx_edge: assert property (ce && cfg.in_fall && ic_rise
    |=> rx_q == $past(rx_q)) else $error("capture on wrong edge");
  chk_alt_route: assert property (alt_to_net == pad_sync[1] &&
    pll_ref_clk == alt_to_net) else $error("alternate route registered");
  chk_resync_fall: assert property (ce && ic_rise |=>
    rx_fall_hold == $past(rx_fall_q)) else $error("resync hold wrong");
  chk_out_invert: assert property (ce && !configuring && cfg.mode == GIO_MODE_OUTPUT
    && cfg.out_reg && !double_edge_io_out_ok |=> pad.out == ($past(tx_q) ^ $past(cfg.invert)))
    else $error("inverted output wrong");
  chk_oe_drive: assert property (ce && !configuring && cfg.mode == GIO_MODE_BIDIR
    && cfg.oe_reg |=> pad.oe_n == !$past(oe_q)) else $error("drive enable wrong");
  chk_no_double_edge_io: assert property (ce && cfg.diff_pin && rx_on |=>
    !fall_sample_to_core) else $error("diff pin double-edge");
  chk_clk_fwd: assert property (ce && !configuring && cfg.mode == GIO_MODE_CLKOUT
    |=> !pad.oe_n && pad.out == $past(oc_sync[1])) else $error("clock not forwarded");
  // path checks: registers, muxes and drive
  chk_out_direct: assert property (ce && !configuring && cfg.mode == GIO_MODE_OUTPUT
    && !double_edge_io_out_ok && !cfg.out_reg |=> !pad.oe_n && pad.out == $past(rise_word_from_core))
    else $error("direct output wrong");
  chk_tx_edge: assert property (ce && cfg.out_fall && oc_rise
    |=> tx_q == $past(tx_q)) else $error("transmit on wrong edge");
  chk_oe_edge: assert property (ce && cfg.oe_fall && oc_rise
    |=> oe_q == $past(oe_q)) else $error("drive enable on wrong edge");
  chk_double_edge_io_rise: assert property (ce && rx_on && double_edge_io_in_ok
    |=> rise_sample_to_core == $past(rx_rise_q)) else $error("rise sample wrong");
  chk_double_edge_io_fall: assert property (ce && rx_on && double_edge_io_in_ok && !cfg.resync
    |=> fall_sample_to_core == $past(rx_fall_q)) else $error("fall sample wrong");
  chk_rx_resync: assert property (ce && rx_on && double_edge_io_in_ok && cfg.resync
    |=> fall_sample_to_core == $past(rx_fall_hold)) else $error("resync sample wrong");
  chk_double_edge_io_mux: assert property (ce && !configuring && cfg.mode == GIO_MODE_OUTPUT
    && double_edge_io_out_ok |=> pad.out == ($past(oc_sync[1]) ? $past(tx_rise_q) : $past(tx_fall_q)))
    else $error("double-edge output wrong");
  chk_diff_tx: assert property (ce && !configuring && cfg.mode == GIO_MODE_OUTPUT
    && cfg.diff_pin && !cfg.out_reg |=> pad.out == $past(rise_word_from_core))
    else $error("diff pin double-edge output");
  chk_drive_off: assert property (ce && !configuring && cfg.mode == GIO_MODE_BIDIR
    && cfg.oe_reg && !oe_q |=> pad.oe_n && (pad.pull_up || pad.pull_dn))
    else $error("released pad not pulled");
  chk_bidir_oe: assert property (ce && !configuring && cfg.mode == GIO_MODE_BIDIR
    && !cfg.oe_reg |=> pad.oe_n == !$past(oe_from_core)) else $error("direct enable wrong");

  // scenario covers
  cov_bidir: cover property (cfg.mode == GIO_MODE_BIDIR && !pad.oe_n ##1 pad.oe_n);
  cov_double_edge_io_in: cover property (double_edge_io_in_ok && cfg.resync && ic_rise);
  cov_double_edge_io_out: cover property (double_edge_io_out_ok && tx_on && oc_fall);
  cov_cfg_end: cover property (configuring ##1 !configuring);
  cov_clk_fwd: cover property (cfg.mode == GIO_MODE_CLKOUT && oc_rise);
endmodule : gio_cell

// ===== hw/gio_pkg.sv
// shared constants and carriers for the gpio logic cell
package gio_pkg;
  // apb register byte offsets
  localparam logic [31:0] GIO_CTRL_OFS   = 32'h0000_0000;
  localparam logic [31:0] GIO_STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] GIO_CTRL_RST   = 32'h0000_0000;

  // mode field encodings
  localparam logic [2:0] GIO_MODE_UNUSED = 3'h0;
  localparam logic [2:0] GIO_MODE_INPUT  = 3'h1;
  localparam logic [2:0] GIO_MODE_OUTPUT = 3'h2;
  localparam logic [2:0] GIO_MODE_BIDIR  = 3'h3;
  localparam logic [2:0] GIO_MODE_CLKOUT = 3'h4;

  // control word width and status width
  localparam int GIO_CTRL_W = 15;
  localparam int GIO_STAT_W = 7;

  // control register layout, msb first
  typedef struct packed {
    logic       diff_pin;   // [14] differential-capable pin
    logic       pull_down;  // [13] default pull is pull-down
    logic       resync;     // [12] double-edge resync mode
    logic       double_edge_io_out;   // [11] double-edge transmit
    logic       double_edge_io_in;    // [10] double-edge receive
    logic       invert;     // [9] invert transmit register
    logic       oe_fall;    // [8] drive-enable reg on falling edge
    logic       out_fall;   // [7] transmit reg on falling edge
    logic       in_fall;    // [6] capture reg on falling edge
    logic       oe_reg;     // [5] drive enable registered
    logic       out_reg;    // [4] transmit registered
    logic       in_reg;     // [3] receive registered
    logic [2:0] mode;       // [2:0] cell mode
  } gio_cfg_type;

  // status register layout, msb first
  typedef struct packed {
    logic pull_dn;      // [6] pull-down applied
    logic pull_up;      // [5] pull-up applied
    logic driving;      // [4] pad driver on
    logic configuring;  // [3] device in configuration
    logic fall_s;       // [2] falling-edge sample
    logic rise_s;       // [1] rising or normal sample
    logic pad;          // [0] synchronised pad level
  } gio_stat_type;

  // pad side carrier
  typedef struct packed {
    logic out;      // level driven to pad
    logic oe_n;     // low while driving
    logic pull_up;  // weak pull-up on
    logic pull_dn;  // weak pull-down on
  } gio_pad_type;
endpackage : gio_pkg

// ===== verification/gio_board.sv
// board circuitry model at the pad: resolves the wire level seen by the cell
`timescale 1ns/1ns
module gio_board
  import gio_pkg::*;
(
  input  wire logic                 clk,      // clock for the float pattern
  input  wire gio_pkg::gio_pad_type pad,      // cell drive and pulls
  input  wire logic                 ext_en,   // board drives the wire
  input  wire logic                 ext_val,  // board drive level
  output      logic                 pad_in    // resolved wire level
);
  logic last = 1'b0;  // last resolved level
  // remember the level so a floating wire keeps changing
  always @(posedge clk) begin
    last <= pad_in;
  end
  // cell driver first, then board, then weak pulls, else float
  always_comb begin
    if (!pad.oe_n) pad_in = pad.out;
    else if (ext_en) pad_in = ext_val;
    else if (pad.pull_up) pad_in = 1'b1;
    else if (pad.pull_dn) pad_in = 1'b0;
    else pad_in = ~last;
  end
endmodule : gio_board

// ===== verification/testbench.sv
// self-checking bench for the gpio logic cell
`timescale 1ns/1ns
module testbench;
  import gio_pkg::*;
  logic        clk, rst_n, ce, psel, penable, pwrite, configuring;  // bench drives
  logic        in_clk, out_clk, rw, fw, oe_c, ext_en, ext_val;      // bench drives
  logic [31:0] paddr, pwdata, prdata, rd;                           // apb data
  logic        pready, pslverr, err, rs, fs, alt, pll, pad_in;      // observed
  gio_pad_type pad;                                                 // pad carrier
  int          failures, checks, cycles;                            // counters
  initial clk = 1'b0;
  always #50 clk = ~clk;
  gio_cell i_gio_cell (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .configuring(configuring), .in_clk(in_clk), .out_clk(out_clk),
    .rise_word_from_core(rw), .fall_word_from_core(fw), .oe_from_core(oe_c),
    .rise_sample_to_core(rs), .fall_sample_to_core(fs), .alt_to_net(alt),
    .pll_ref_clk(pll), .pad_in(pad_in), .pad(pad));
  gio_board i_gio_board (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  // compare seen against expected
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // one apb transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // wait cycles, then step a core clock past its synchroniser
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic tog_in(input logic v);
    in_clk <= v;
    wt(6);
  endtask : tog_in
  task automatic tog_out(input logic v);
    out_clk <= v;
    wt(6);
  endtask : tog_out
  // pad field comparisons
  task automatic drv(input string n, input logic o, input logic e);
    check(n, {30'h0, pad.out, pad.oe_n}, {30'h0, o, e});
  endtask : drv
  task automatic pul(input string n, input logic e, input logic u, input logic d);
    check(n, {29'h0, pad.oe_n, pad.pull_up, pad.pull_dn}, {29'h0, e, u, d});
  endtask : pul
  initial begin
    {rst_n, psel, penable, pwrite, configuring, in_clk, out_clk} = 7'h00;
    {rw, fw, oe_c, ext_en, ext_val} = 5'h00;
    {paddr, pwdata} = 64'h0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset value and idle pad
    apb(1'b0, GIO_CTRL_OFS, 32'h0);
    check("ctrl_reset", rd, GIO_CTRL_RST);
    check("apb_ready", {31'h0, pready}, 32'h1);
    pul("unused_pull", 1'b1, 1'b1, 1'b0);
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_2000);
    wt(2);
    pul("unused_pulldn", 1'b1, 1'b0, 1'b1);
    // configuration phase pulls
    configuring <= 1'b1;
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0002);
    wt(2);
    pul("cfg_pull", 1'b1, 1'b1, 1'b0);
    apb(1'b0, GIO_STATUS_OFS, 32'h0);
    check("cfg_status", rd[3], 32'h1);
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_4000);
    wt(2);
    pul("cfg_diff", 1'b1, 1'b0, 1'b0);
    configuring <= 1'b0;
    // direct output
    rw <= 1'b1;
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0002);
    wt(2);
    drv("out_direct1", 1'b1, 1'b0);
    rw <= 1'b0;
    wt(2);
    drv("out_direct0", 1'b0, 1'b0);
    // registered inverted output on out_clk rise
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0212);
    rw <= 1'b1;
    tog_out(1'b1);
    drv("out_inv", 1'b0, 1'b0);
    rw <= 1'b0;
    tog_out(1'b0);
    drv("out_hold", 1'b0, 1'b0);
    tog_out(1'b1);
    drv("out_inv2", 1'b1, 1'b0);
    tog_out(1'b0);
    // direct input and alternate route
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0001);
    ext_en  <= 1'b1;
    ext_val <= 1'b1;
    wt(6);
    check("in_direct", rs, 32'h1);
    check("alt_route", alt, 32'h1);
    check("pll_ref", pll, 32'h1);
    check("in_no_drive", pad.oe_n, 32'h1);
    ext_val <= 1'b0;
    wt(6);
    check("in_direct0", {alt, rs}, 32'h0);
    // registered capture on falling in_clk
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0049);
    ext_val <= 1'b1;
    tog_in(1'b1);
    check("in_fall_wait", rs, 32'h0);
    tog_in(1'b0);
    check("in_fall_cap", rs, 32'h1);
    // double-edge capture, rise first
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0409);
    ext_val <= 1'b0;
    tog_in(1'b1);
    ext_val <= 1'b1;
    tog_in(1'b0);
    check("double_edge_io_in", {fs, rs}, 32'h2);
    ext_val <= 1'b0;
    wt(6);
    check("alt_comb", {alt, rs}, 32'h0);
    // resync moves the falling sample to the next rise
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_1409);
    tog_in(1'b1);
    tog_in(1'b0);
    tog_in(1'b1);
    ext_val <= 1'b1;
    tog_in(1'b0);
    check("resync_wait", fs, 32'h0);
    tog_in(1'b1);
    check("resync_rise", fs, 32'h1);
    tog_in(1'b0);
    // differential pin ignores double-edge
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_4409);
    ext_val <= 1'b1;
    tog_in(1'b1);
    tog_in(1'b0);
    check("diff_no_double_edge_io", {fs, rs}, 32'h1);
    // bidirectional with registered drive enable
    ext_en <= 1'b0;
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0023);
    oe_c <= 1'b1;
    rw   <= 1'b1;
    wt(6);
    check("oe_reg_wait", pad.oe_n, 32'h1);
    tog_out(1'b1);
    drv("bidir_drive", 1'b1, 1'b0);
    check("bidir_rx", rs, 32'h1);
    oe_c <= 1'b0;
    tog_out(1'b0);
    tog_out(1'b1);
    pul("bidir_off", 1'b1, 1'b1, 1'b0);
    tog_out(1'b0);
    // bidirectional, output side on falling edges, capture on rising
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_01BB);
    oe_c <= 1'b1;
    tog_out(1'b1);
    check("oe_fall_wait", pad.oe_n, 32'h1);
    tog_out(1'b0);
    drv("bidir_fall", 1'b1, 1'b0);
    rw <= 1'b0;
    tog_out(1'b1);
    tog_out(1'b0);
    tog_in(1'b1);
    check("bidir_rx_reg", {fs, rs}, 32'h0);
    oe_c <= 1'b0;
    rw   <= 1'b1;
    tog_out(1'b1);
    tog_out(1'b0);
    // double-edge output
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0802);
    fw <= 1'b0;
    tog_out(1'b1);
    drv("double_edge_io_out_hi", 1'b1, 1'b0);
    tog_out(1'b0);
    drv("double_edge_io_out_lo", 1'b0, 1'b0);
    // clock output forwards out_clk
    apb(1'b1, GIO_CTRL_OFS, 32'h0000_0004);
    tog_out(1'b1);
    drv("clkout_hi", 1'b1, 1'b0);
    tog_out(1'b0);
    drv("clkout_lo", 1'b0, 1'b0);
    // clock enable low freezes the pad
    ce <= 1'b0;
    tog_out(1'b1);
    drv("ce_frozen", 1'b0, 1'b0);
    ce <= 1'b1;
    tog_out(1'b0);
    // refused accesses
    apb(1'b1, 32'h0000_0008, 32'h0000_7FFF);
    check("bad_wr_err", err, 32'h1);
    apb(1'b0, 32'h0000_0008, 32'h0);
    check("bad_rd", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, GIO_STATUS_OFS, 32'h0000_7FFF);
    apb(1'b0, GIO_CTRL_OFS, 32'h0);
    check("ctrl_kept", rd, 32'h0000_0004);
    complete_run();
  end
endmodule : testbench
